// ==== hdl/vci_map.svh ====
`ifndef VCI_MAP_SVH
`define VCI_MAP_SVH
// ------------------------------------------------------------
// address regions: 4KB page numbers, addr[31:12]
// ------------------------------------------------------------
`define VCI_CTRL_PAGE    20'h00001
`define VCI_CPUIF_PAGE   20'h00002
// ------------------------------------------------------------
// guest-visible offsets, physical cpu interface layout
// ------------------------------------------------------------
`define VCI_OFS_CTLR     12'h000
`define VCI_OFS_PMR      12'h004
`define VCI_OFS_IAR      12'h00C
`define VCI_OFS_EOIR     12'h010
`define VCI_OFS_RPR      12'h014
`define VCI_OFS_HPPIR    12'h018
// ------------------------------------------------------------
// control region: list entries, one word each from here
// ------------------------------------------------------------
`define VCI_OFS_LR0      12'h100
// ------------------------------------------------------------
// list entry word fields
// ------------------------------------------------------------
`define VCI_LR_ID        9:0
`define VCI_LR_PRIO      19:12
`define VCI_LR_STATE     29:28
`define VCI_LR_GRP       30
// ------------------------------------------------------------
// guest control fields and values
// ------------------------------------------------------------
`define VCI_CTLR_EN      1:0
`define VCI_PMR_F        7:0
`define VCI_RST_CTLR     2'h0
`define VCI_RST_PMR      8'h00
`define VCI_PRIO_IDLE    8'hFF
`define VCI_SPURIOUS_ID  10'h3FF
`endif

// ==== hdl/vci_pkg.sv ====
package vci_pkg;
    // list entry state, two bits as stored in the entry word
    typedef enum logic [1:0] {
        lr_invalid  = 2'b00,
        lr_pending  = 2'b01,
        lr_active   = 2'b10,
        lr_act_pend = 2'b11
    } vci_lr_state_t;
endpackage : vci_pkg

// ==== hdl/vci_virt_cpu_if.sv ====
`timescale 1ns/1ns
`include "vci_map.svh"

module vci_virt_cpu_if #(
    parameter int NUM_LR = 4                 // list entries
) (
    input  wire logic        clk_sys,        // system clock
    input  wire logic        arst_n,         // async reset
    input  wire logic        g_rd,           // guest read strobe
    input  wire logic        g_wr,           // guest write strobe
    input  wire logic        g_ns,           // guest access non-secure
    input  wire logic [31:0] g_addr,         // guest byte address
    input  wire logic [31:0] g_wdata,        // guest write data
    output logic             g_rvalid,       // guest read answer
    output logic      [31:0] g_rdata,        // guest read data
    input  wire logic        h_wr,           // hypervisor write strobe
    input  wire logic        h_ns,           // hypervisor non-secure
    input  wire logic [31:0] h_addr,         // hypervisor byte address
    input  wire logic [31:0] h_wdata,        // hypervisor write data
    output logic             vfiq,           // virtual fiq to guest
    output logic             virq            // virtual irq to guest
);
    import vci_pkg::*;

    localparam int IW = (NUM_LR > 1) ? $clog2(NUM_LR) : 1;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    vci_lr_state_t      lr_state [NUM_LR];
    logic               lr_grp   [NUM_LR];
    logic [7:0]         lr_prio  [NUM_LR];
    logic [9:0]         lr_id    [NUM_LR];
    vci_lr_state_t      next_lr_state [NUM_LR];
    logic               next_lr_grp   [NUM_LR];
    logic [7:0]         next_lr_prio  [NUM_LR];
    logic [9:0]         next_lr_id    [NUM_LR];
    logic [1:0]         ctlr_en;
    logic [7:0]         pmr;
    logic [1:0]         next_ctlr_en;
    logic [7:0]         next_pmr;
    logic               next_g_rvalid;
    logic [31:0]        next_g_rdata;
    logic               next_vfiq;
    logic               next_virq;

    logic               g_hit;
    logic               h_hit;
    logic [11:0]        g_ofs;
    logic [11:0]        h_ofs;
    logic               h_lr_wr;
    logic [IW-1:0]      h_idx;
    logic               iar_rd;
    logic               eoi_wr;
    logic               ack_take;
    logic               best_vld;
    logic [IW-1:0]      best_idx;
    logic [7:0]         best_prio;
    logic [9:0]         best_id;
    logic               best_grp;
    logic [7:0]         run_prio;
    logic               sig_ok;
    logic [NUM_LR-1:0]  eoi_match;
    logic [NUM_LR-1:0]  act_mask;
    logic [2*NUM_LR-1:0] st_vec;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // secure accesses fall through as if nothing were mapped there
    assign g_hit   = g_ns && (g_addr[31:12] == `VCI_CPUIF_PAGE);
    assign h_hit   = h_ns && (h_addr[31:12] == `VCI_CTRL_PAGE);
    assign g_ofs   = g_addr[11:0];
    assign h_ofs   = h_addr[11:0] - `VCI_OFS_LR0;
    assign h_lr_wr = h_wr && h_hit && (h_ofs < 12'(NUM_LR * 4)) && (h_ofs[1:0] == 2'h0);
    assign h_idx   = h_ofs[IW+1:2];
    assign iar_rd  = g_rd && g_hit && (g_ofs == `VCI_OFS_IAR);
    assign eoi_wr  = g_wr && g_hit && (g_ofs == `VCI_OFS_EOIR);

    // ------------------------------------------------------------
    // best pending entry and running priority
    // ------------------------------------------------------------
    // lower value is higher priority; ties go to the lower index
    always_comb begin
        best_vld  = 1'b0;
        best_idx  = '0;
        best_prio = `VCI_PRIO_IDLE;
        run_prio  = `VCI_PRIO_IDLE;
        for (int i = 0; i < NUM_LR; i++) begin
            if (lr_state[i] == lr_pending && ctlr_en[lr_grp[i]] && lr_prio[i] < best_prio) begin
                best_vld  = 1'b1;
                best_idx  = IW'(i);
                best_prio = lr_prio[i];
            end
            if (lr_state[i][1] && lr_prio[i] < run_prio) begin
                run_prio = lr_prio[i];
            end
        end
    end

    assign best_id  = lr_id[best_idx];
    assign best_grp = lr_grp[best_idx];
    assign sig_ok   = best_vld && (best_prio < pmr) && (best_prio < run_prio);
    assign ack_take = iar_rd && sig_ok;

    // ------------------------------------------------------------
    // per-entry next state
    // ------------------------------------------------------------
    // a hypervisor write wins over a guest ack or eoi to the same entry
    for (genvar i = 0; i < NUM_LR; i++) begin : g_lr
        assign eoi_match[i] = lr_state[i][1] && (lr_id[i] == g_wdata[`VCI_LR_ID]);
        assign act_mask[i]  = lr_state[i][1];
        assign st_vec[2*i +: 2] = lr_state[i];

        always_comb begin
            next_lr_state[i] = lr_state[i];
            next_lr_grp[i]   = lr_grp[i];
            next_lr_prio[i]  = lr_prio[i];
            next_lr_id[i]    = lr_id[i];
            if (h_lr_wr && h_idx == IW'(i)) begin
                next_lr_state[i] = vci_lr_state_t'(h_wdata[`VCI_LR_STATE]);
                next_lr_grp[i]   = h_wdata[`VCI_LR_GRP];
                next_lr_prio[i]  = h_wdata[`VCI_LR_PRIO];
                next_lr_id[i]    = h_wdata[`VCI_LR_ID];
            end else if (ack_take && best_idx == IW'(i)) begin
                next_lr_state[i] = lr_active;
            end else if (eoi_wr && eoi_match[i]) begin
                // active-and-pending keeps its pending half
                next_lr_state[i] = (lr_state[i] == lr_act_pend) ? lr_pending : lr_invalid;
            end
        end

        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                lr_state[i] <= lr_invalid;
                lr_grp[i]   <= 1'b0;
                lr_prio[i]  <= `VCI_PRIO_IDLE;
                lr_id[i]    <= 10'h000;
            end else begin
                lr_state[i] <= next_lr_state[i];
                lr_grp[i]   <= next_lr_grp[i];
                lr_prio[i]  <= next_lr_prio[i];
                lr_id[i]    <= next_lr_id[i];
            end
        end
    end
    // an eoi naming no entry falls through every branch above

    // ------------------------------------------------------------
    // guest registers, read answer and outputs
    // ------------------------------------------------------------
    always_comb begin
        next_ctlr_en  = ctlr_en;
        next_pmr      = pmr;
        next_g_rvalid = g_rd;
        next_g_rdata  = 32'h0000_0000;
        if (g_wr && g_hit && g_ofs == `VCI_OFS_CTLR) begin
            next_ctlr_en = g_wdata[`VCI_CTLR_EN];
        end
        if (g_wr && g_hit && g_ofs == `VCI_OFS_PMR) begin
            next_pmr = g_wdata[`VCI_PMR_F];
        end
        if (g_rd && g_hit) begin
            case (g_ofs)
                `VCI_OFS_CTLR:  next_g_rdata = {30'h0, ctlr_en};
                `VCI_OFS_PMR:   next_g_rdata = {24'h0, pmr};
                `VCI_OFS_IAR:   next_g_rdata = {22'h0, ack_take ? best_id : `VCI_SPURIOUS_ID};
                `VCI_OFS_RPR:   next_g_rdata = {24'h0, run_prio};
                `VCI_OFS_HPPIR: next_g_rdata = {22'h0, best_vld ? best_id : `VCI_SPURIOUS_ID};
                default:        next_g_rdata = 32'h0000_0000;
            endcase
        end
        // registered outputs cost a cycle but keep the guest pins glitch free
        next_vfiq = sig_ok && !best_grp;
        next_virq = sig_ok && best_grp;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctlr_en  <= `VCI_RST_CTLR;
            pmr      <= `VCI_RST_PMR;
            g_rvalid <= 1'b0;
            g_rdata  <= 32'h0000_0000;
            vfiq     <= 1'b0;
            virq     <= 1'b0;
        end else begin
            ctlr_en  <= next_ctlr_en;
            pmr      <= next_pmr;
            g_rvalid <= next_g_rvalid;
            g_rdata  <= next_g_rdata;
            vfiq     <= next_vfiq;
            virq     <= next_virq;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_ack;
        iar_rd && sig_ok && !h_lr_wr;
    endsequence

    sequence s_eoi_hit;
        eoi_wr && (|eoi_match) && !h_lr_wr && !ack_take;
    endsequence

    chk_page_split: assert property (g_wr && !g_hit |=> $stable(pmr) && $stable(ctlr_en))
        else $error("guest write outside its page changed a register");
    chk_secure_void: assert property (g_rd && !g_ns |=> g_rvalid && g_rdata == 32'h0000_0000)
        else $error("secure read saw guest register data");
    chk_prio_gate: assert property ((vfiq || virq) |-> $past(best_prio) < $past(pmr))
        else $error("interrupt signaled above priority mask");
    chk_group_route: assert property (vfiq |-> !$past(best_grp))
        else $error("group 1 entry drove virtual fiq");
    chk_ack_id: assert property (s_ack |=> g_rvalid && g_rdata[9:0] == $past(best_id))
        else $error("acknowledge returned wrong id");
    chk_ack_active: assert property (s_ack |=> lr_state[$past(best_idx)] == lr_active)
        else $error("acknowledged entry not active");
    chk_eoi_deact: assert property (s_eoi_hit |=> ($past(eoi_match) & act_mask) == '0)
        else $error("matching entry still active after eoi");
    chk_eoi_miss: assert property (eoi_wr && !(|eoi_match) && !h_lr_wr && !ack_take
                                   |=> $stable(st_vec))
        else $error("unmatched eoi changed an entry");
    chk_quiet: assert property (!sig_ok |=> !vfiq && !virq)
        else $error("output raised with no qualifying entry");
    chk_spurious: assert property (iar_rd && !sig_ok |=> g_rdata[9:0] == `VCI_SPURIOUS_ID)
        else $error("no spurious id when nothing qualifies");

endmodule : vci_virt_cpu_if

// ==== tb/vci_guest_model.sv ====
`timescale 1ns/1ns
// ------------------------------------------------------------
// guest core model: drives the guest register bus
// ------------------------------------------------------------
module vci_guest_model (
    input  wire logic        clk_sys, // system clock
    output logic             g_rd,    // read strobe
    output logic             g_wr,    // write strobe
    output logic             g_ns,    // access non-secure
    output logic      [31:0] g_addr,  // byte address
    output logic      [31:0] g_wdata  // write data
);
    // idle bus at time zero
    initial begin
        g_rd = 1'b0;
        g_wr = 1'b0;
        g_ns = 1'b1;
        g_addr = 32'h0;
        g_wdata = 32'h0;
    end

    // one access: strobe held one cycle, launched off the sampling edge
    task acc(input logic rd, input logic ns, input logic [31:0] a, input logic [31:0] d);
        @(negedge clk_sys);
        g_rd <= rd;
        g_wr <= !rd;
        g_ns <= ns;
        g_addr <= a;
        g_wdata <= d;
        @(negedge clk_sys);
        g_rd <= 1'b0;
        g_wr <= 1'b0;
        // released lines must not keep showing the old value
        g_ns <= !ns;
        g_addr <= ~a;
        g_wdata <= ~d;
    endtask : acc
endmodule : vci_guest_model

// ==== tb/tb_virtual_cpu_interrupt_interface.sv ====
`timescale 1ns/1ns
`include "vci_map.svh"
module tb_virtual_cpu_interrupt_interface;
    logic        clk_sys;
    logic        arst_n;
    logic        g_rd, g_wr, g_ns, g_rvalid;
    logic [31:0] g_addr, g_wdata, g_rdata;
    logic        h_wr, h_ns, vfiq, virq;
    logic [31:0] h_addr, h_wdata;
    logic [31:0] exp_q[$];
    logic [9:0]  id_a, id_b;
    int          miscompares, check_count;

    vci_guest_model guest (.clk_sys(clk_sys), .g_rd(g_rd), .g_wr(g_wr), .g_ns(g_ns),
                           .g_addr(g_addr), .g_wdata(g_wdata));
    vci_virt_cpu_if #(.NUM_LR(4)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .g_rd(g_rd),
        .g_wr(g_wr), .g_ns(g_ns), .g_addr(g_addr), .g_wdata(g_wdata), .g_rvalid(g_rvalid),
        .g_rdata(g_rdata), .h_wr(h_wr), .h_ns(h_ns), .h_addr(h_addr), .h_wdata(h_wdata),
        .vfiq(vfiq), .virq(virq));

    // ------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------
    task chk_rd(input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk_rd
    task chk_lvl(input logic [1:0] e);
        check_count++;
        if ({vfiq, virq} !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, {vfiq, virq});
        end
    endtask : chk_lvl
    task tally_and_finish;
        if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // stimulus helpers
    // ------------------------------------------------------------
    function logic [31:0] cpu_a(input logic [11:0] ofs);
        return {`VCI_CPUIF_PAGE, ofs};
    endfunction : cpu_a
    // pending entry word: group, priority, id
    function logic [31:0] lrw(input logic grp, input logic [7:0] p, input logic [9:0] id);
        return {1'b0, grp, 2'b01, 8'h00, p, 2'b00, id};
    endfunction : lrw
    // guest read with its expected answer noted first
    task grd(input logic ns, input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        guest.acc(1'b1, ns, a, 32'h0);
    endtask : grd
    task hw(input logic ns, input logic [1:0] n, input logic [31:0] d);
        @(negedge clk_sys);
        h_wr <= 1'b1;
        h_ns <= ns;
        h_addr <= {`VCI_CTRL_PAGE, `VCI_OFS_LR0 + {8'h00, n, 2'b00}};
        h_wdata <= d;
        @(negedge clk_sys);
        h_wr <= 1'b0;
        h_addr <= 32'hFFFF_FFFF;
        h_wdata <= ~d;
    endtask : hw
    // outputs are registered: allow cause plus one edge to land
    task settle;
        repeat (3) @(negedge clk_sys);
    endtask : settle

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // read answers taken off the queue as they appear
    always @(negedge clk_sys) begin
        if (g_rvalid === 1'b1) begin
            if (exp_q.size() == 0) chk_rd(32'hDEAD_BEEF, g_rdata);
            else chk_rd(exp_q.pop_front(), g_rdata);
        end
    end

    initial begin
        #50000;
        miscompares++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        h_wr = 1'b0;
        h_ns = 1'b1;
        h_addr = 32'h0;
        h_wdata = 32'h0;
        miscompares = 0;
        check_count = 0;
        void'($urandom(87058));
        id_a = 10'($urandom_range(1, 500));
        id_b = id_a + 10'h100;
        repeat (5) @(negedge clk_sys);
        arst_n = 1'b1;
        grd(1'b1, cpu_a(`VCI_OFS_IAR), 32'h3FF);
        chk_lvl(2'h0);
        guest.acc(1'b0, 1'b1, cpu_a(`VCI_OFS_CTLR), 32'h3);
        guest.acc(1'b0, 1'b1, cpu_a(`VCI_OFS_PMR), 32'hF0);
        hw(1'b1, 2'h0, lrw(1'b1, 8'h40, id_a));
        hw(1'b0, 2'h1, lrw(1'b0, 8'h10, id_b));
        settle();
        chk_lvl(2'h1);
        hw(1'b1, 2'h1, lrw(1'b0, 8'h20, id_b));
        settle();
        chk_lvl(2'h2);
        grd(1'b1, cpu_a(`VCI_OFS_IAR), {22'h0, id_b});
        settle();
        chk_lvl(2'h0);
        grd(1'b1, cpu_a(`VCI_OFS_RPR), 32'h20);
        guest.acc(1'b0, 1'b1, cpu_a(`VCI_OFS_EOIR), 32'h3F0);
        settle();
        chk_lvl(2'h0);
        guest.acc(1'b0, 1'b1, cpu_a(`VCI_OFS_EOIR), {22'h0, id_b});
        settle();
        chk_lvl(2'h1);
        grd(1'b1, cpu_a(`VCI_OFS_RPR), 32'hFF);
        grd(1'b0, cpu_a(`VCI_OFS_HPPIR), 32'h0);
        grd(1'b1, {`VCI_CTRL_PAGE, `VCI_OFS_HPPIR}, 32'h0);
        grd(1'b1, cpu_a(`VCI_OFS_HPPIR), {22'h0, id_a});
        guest.acc(1'b0, 1'b1, cpu_a(`VCI_OFS_PMR), 32'h40);
        settle();
        chk_lvl(2'h0);
        // secure and out-of-page writes must leave the mask alone
        guest.acc(1'b0, 1'b0, cpu_a(`VCI_OFS_PMR), 32'h0);
        guest.acc(1'b0, 1'b1, {`VCI_CTRL_PAGE, `VCI_OFS_PMR}, 32'h0);
        grd(1'b1, cpu_a(`VCI_OFS_PMR), 32'h40);
        // group enable gates signaling and the pending id view
        guest.acc(1'b0, 1'b1, cpu_a(`VCI_OFS_PMR), 32'hF0);
        settle();
        chk_lvl(2'h1);
        guest.acc(1'b0, 1'b1, cpu_a(`VCI_OFS_CTLR), 32'h1);
        settle();
        chk_lvl(2'h0);
        grd(1'b1, cpu_a(`VCI_OFS_CTLR), 32'h1);
        grd(1'b1, cpu_a(`VCI_OFS_HPPIR), 32'h3FF);
        // active-and-pending entry keeps its pending half on eoi
        hw(1'b1, 2'h2, lrw(1'b0, 8'h30, id_b) | 32'h2000_0000);
        settle();
        chk_lvl(2'h0);
        guest.acc(1'b0, 1'b1, cpu_a(`VCI_OFS_EOIR), {22'h0, id_b});
        settle();
        chk_lvl(2'h2);
        grd(1'b1, cpu_a(`VCI_OFS_IAR), {22'h0, id_b});
        settle();
        if (exp_q.size() != 0) chk_rd(32'h0, 32'(exp_q.size()));
        tally_and_finish();
    end
endmodule : tb_virtual_cpu_interrupt_interface
